// ==== rtl/nand_bus_regs.vh ====
// Bus cycle constants for the NAND host controller
`ifndef NAND_BUS_REGS_VH
`define NAND_BUS_REGS_VH
// Request kinds on the command port
`define KIND_CMD 3'h0
`define KIND_ADDR 3'h1
`define KIND_DIN 3'h2
`define KIND_DOUT 3'h3
`define KIND_ROWCOL 3'h4
// Address field widths and address cycle count
`define COL_BITS 13
`define WL_BITS 6
`define BLK_BITS 11
`define ADDR_CYCLES 3'h5
// Strobe timing: each strobe phase lasts at least this long, in ns
`define STROBE_NS 20
`define CLK_NS 5
`define STROBE_CYC ((`STROBE_NS + `CLK_NS - 1) / `CLK_NS)
`endif

// ==== rtl/byte_fifo.v ====
// Synchronous FIFO with valid/ready on both sides
module byte_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire ref_clk,
  input wire reset_n,
  input wire [WIDTH-1:0] in_data,
  input wire in_valid,
  output wire in_ready,
  output wire [WIDTH-1:0] out_data,
  output wire out_valid,
  input wire out_ready
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_q;
  reg [AW-1:0] rd_q;
  reg [AW:0] cnt_q;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  assign in_ready = (cnt_q != DEPTH[AW:0]);
  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign out_data = mem[rd_q];
  always @(posedge ref_clk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_q <= {AW{1'b0}};
      rd_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule

// ==== rtl/strobe_timer.v ====
// Down counter that paces strobe phases
module strobe_timer #(
  parameter CW = 4
) (
  input wire ref_clk,
  input wire reset_n,
  input wire start,
  input wire [CW-1:0] length,
  output wire done
);
  reg [CW-1:0] cnt_q;
  // Done ignores start so that a caller may restart from done without a loop
  assign done = (cnt_q == {CW{1'b0}});
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q <= {CW{1'b0}};
    end else if (start) begin
      cnt_q <= length;
    end else if (cnt_q != {CW{1'b0}}) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end
endmodule

// ==== rtl/nand_host.v ====
// Host controller driving the NAND asynchronous bus cycles
// Functional notes
// - Command latched on strobe rise, cle only
// - Address latched on strobe rise, ale only
// - Full address is five address cycles
// - Data in: both latches low, guard high
// - Data out by toggling output strobe
// - Guard high for program/erase setup cycles
// - Cycle 1 carries column bits 7..0
// - Cycle 2 column 12..8, top bits low
// - Cycle 3 wordline 5..0, block 1..0
// - Cycle 4 carries block bits 9..2
// - Cycle 5 block bit 10, rest low
// - Column bit12 set with bits 10..7 nonzero is rejected
// - Output strobe high while device busy
`include "nand_bus_regs.vh"
module nand_host #(
  parameter FIFO_DEPTH = 8,
  parameter FIFO_AW = 3
) (
  input wire ref_clk,
  input wire reset_n,
  // Request port
  input wire req_valid,
  output reg req_ready,
  input wire [2:0] req_kind,
  input wire [7:0] req_byte,
  input wire [`COL_BITS-1:0] req_col,
  input wire [`WL_BITS-1:0] req_wl,
  input wire [`BLK_BITS-1:0] req_blk,
  input wire req_modify,
  // Read data stream
  output wire rd_valid,
  input wire rd_ready,
  output wire [7:0] rd_byte,
  output reg busy,
  output reg addr_error,
  // NAND pins
  output reg chip_select_n,
  output reg command_latch_en,
  output reg address_latch_en,
  output reg write_strobe_n,
  output reg output_strobe_n,
  output reg write_guard_n,
  input wire ready_busy_n,
  input wire [7:0] io_in,
  output reg [7:0] io_out,
  output reg io_oe
);
  localparam S_IDLE = 3'h0;
  localparam S_SETUP = 3'h1;
  localparam S_LOW = 3'h2;
  localparam S_HIGH = 3'h3;
  localparam S_RLOW = 3'h4;
  localparam S_RHIGH = 3'h5;
  localparam S_WAITRB = 3'h6;
  // Address cycle indices within the five-cycle address phase
  localparam [2:0] AC_COL_LO = 3'h0;
  localparam [2:0] AC_COL_HI = 3'h1;
  localparam [2:0] AC_ROW_LO = 3'h2;
  localparam [2:0] AC_ROW_MID = 3'h3;
  localparam [2:0] AC_ROW_HI = 3'h4;
  localparam [2:0] AC_LAST = `ADDR_CYCLES - 3'h1;
  // The phase length is a plain integer; only the timer's width is kept, on purpose
  localparam [31:0] STROBE_FULL = `STROBE_CYC;
  localparam [3:0] STROBE_LEN = STROBE_FULL[3:0];

  reg [2:0] state_q;
  reg [2:0] kind_q;
  reg [2:0] cyc_q;
  reg [`COL_BITS-1:0] col_q;
  reg [`WL_BITS-1:0] wl_q;
  reg [`BLK_BITS-1:0] blk_q;
  reg tmr_start;
  wire tmr_done;
  reg push_q;
  reg [7:0] push_byte_q;
  wire fifo_in_ready;
  wire read_go;
  wire addr_more;

  // Address cycle bytes from the latched column and row
  function [7:0] addr_byte;
    input [2:0] n;
    input [`COL_BITS-1:0] c;
    input [`WL_BITS-1:0] w;
    input [`BLK_BITS-1:0] b;
    begin
      case (n)
        AC_COL_LO: addr_byte = c[7:0];
        AC_COL_HI: addr_byte = {3'h0, c[12:8]};
        AC_ROW_LO: addr_byte = {b[1:0], w};
        AC_ROW_MID: addr_byte = b[9:2];
        AC_ROW_HI: addr_byte = {7'h00, b[10]};
        default: addr_byte = 8'h00;
      endcase
    end
  endfunction

  // 11 block bits: the fifth cycle carries only block bit 10, IO1 stays low
  function col_bad;
    input [`COL_BITS-1:0] c;
    begin
      col_bad = c[12] && (c[10:7] != 4'h0);
    end
  endfunction

  strobe_timer #(.CW(4)) u_tmr (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .start(tmr_start),
    .length(STROBE_LEN),
    .done(tmr_done)
  );

  byte_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_fifo (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .in_data(push_byte_q),
    .in_valid(push_q),
    .in_ready(fifo_in_ready),
    .out_data(rd_byte),
    .out_valid(rd_valid),
    .out_ready(rd_ready)
  );

  // Read strobe falls only once the array is ready and the buffer has room
  assign read_go = ready_busy_n && fifo_in_ready && !push_q;
  // Timer restart and state step share this test so the phases cannot drift apart
  assign addr_more = (kind_q == `KIND_ROWCOL) && (cyc_q != AC_LAST);

  always @* begin
    tmr_start = 1'b0;
    case (state_q)
      S_IDLE: tmr_start = req_valid && req_ready;
      S_SETUP: tmr_start = tmr_done;
      S_LOW: tmr_start = tmr_done;
      S_HIGH: tmr_start = tmr_done && addr_more;
      S_WAITRB: tmr_start = read_go;
      S_RLOW: tmr_start = tmr_done;
      default: tmr_start = 1'b0;
    endcase
  end

  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= S_IDLE;
      kind_q <= `KIND_CMD;
      cyc_q <= 3'h0;
      col_q <= {`COL_BITS{1'b0}};
      wl_q <= {`WL_BITS{1'b0}};
      blk_q <= {`BLK_BITS{1'b0}};
      req_ready <= 1'b0;
      busy <= 1'b0;
      addr_error <= 1'b0;
      chip_select_n <= 1'b1;
      command_latch_en <= 1'b0;
      address_latch_en <= 1'b0;
      write_strobe_n <= 1'b1;
      output_strobe_n <= 1'b1;
      write_guard_n <= 1'b0;
      io_out <= 8'h00;
      io_oe <= 1'b0;
      push_q <= 1'b0;
      push_byte_q <= 8'h00;
    end else begin
      push_q <= 1'b0;
      addr_error <= 1'b0;
      case (state_q)
        S_IDLE: begin
          // Idle deselects the device and releases the bus
          chip_select_n <= 1'b1;
          io_oe <= 1'b0;
          // Guard stays low outside modify sequences so stray cycles cannot alter the array
          write_guard_n <= 1'b0;
          req_ready <= 1'b1;
          if (req_valid && req_ready) begin
            req_ready <= 1'b0;
            kind_q <= req_kind;
            busy <= 1'b1;
            cyc_q <= 3'h0;
            chip_select_n <= 1'b0;
            write_guard_n <= req_modify;
            case (req_kind)
              `KIND_CMD: begin
                command_latch_en <= 1'b1;
                address_latch_en <= 1'b0;
                io_out <= req_byte;
                io_oe <= 1'b1;
                state_q <= S_SETUP;
              end
              `KIND_ADDR: begin
                command_latch_en <= 1'b0;
                address_latch_en <= 1'b1;
                io_out <= req_byte;
                io_oe <= 1'b1;
                state_q <= S_SETUP;
              end
              `KIND_DIN: begin
                command_latch_en <= 1'b0;
                address_latch_en <= 1'b0;
                io_out <= req_byte;
                io_oe <= 1'b1;
                state_q <= S_SETUP;
              end
              `KIND_DOUT: begin
                command_latch_en <= 1'b0;
                address_latch_en <= 1'b0;
                io_oe <= 1'b0;
                state_q <= S_WAITRB;
              end
              `KIND_ROWCOL: begin
                if (col_bad(req_col)) begin
                  addr_error <= 1'b1;
                  busy <= 1'b0;
                  chip_select_n <= 1'b1;
                  state_q <= S_IDLE;
                end else begin
                  col_q <= req_col;
                  wl_q <= req_wl;
                  blk_q <= req_blk;
                  command_latch_en <= 1'b0;
                  address_latch_en <= 1'b1;
                  io_out <= addr_byte(AC_COL_LO, req_col, req_wl, req_blk);
                  io_oe <= 1'b1;
                  state_q <= S_SETUP;
                end
              end
              default: begin
                busy <= 1'b0;
                chip_select_n <= 1'b1;
                state_q <= S_IDLE;
              end
            endcase
          end
        end
        S_SETUP: begin
          if (tmr_done) begin
            write_strobe_n <= 1'b0;
            state_q <= S_LOW;
          end
        end
        S_LOW: begin
          if (tmr_done) begin
            // Rising edge latches with both latches never high together
            write_strobe_n <= 1'b1;
            state_q <= S_HIGH;
          end
        end
        S_HIGH: begin
          if (tmr_done) begin
            if (addr_more) begin
              cyc_q <= cyc_q + 3'h1;
              io_out <= addr_byte(cyc_q + 3'h1, col_q, wl_q, blk_q);
              state_q <= S_SETUP;
            end else begin
              command_latch_en <= 1'b0;
              address_latch_en <= 1'b0;
              io_oe <= 1'b0;
              busy <= 1'b0;
              state_q <= S_IDLE;
            end
          end
        end
        S_WAITRB: begin
          // Strobe held high until the array read finishes and the FIFO has room
          if (read_go) begin
            output_strobe_n <= 1'b0;
            state_q <= S_RLOW;
          end
        end
        S_RLOW: begin
          if (tmr_done) begin
            push_byte_q <= io_in;
            push_q <= 1'b1;
            output_strobe_n <= 1'b1;
            state_q <= S_RHIGH;
          end
        end
        S_RHIGH: begin
          if (tmr_done) begin
            busy <= 1'b0;
            state_q <= S_IDLE;
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end
endmodule

// ==== verif/nand_host_props.sv ====
// Pin sequencing checker for the NAND host controller
module nand_host_props (
  input wire ref_clk,
  input wire reset_n,
  input wire addr_error,
  input wire chip_select_n,
  input wire command_latch_en,
  input wire address_latch_en,
  input wire write_strobe_n,
  input wire output_strobe_n,
  input wire write_guard_n,
  input wire ready_busy_n,
  input wire [7:0] io_out,
  input wire io_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  a_cmd_latch_clean: assert property ($rose(write_strobe_n) && command_latch_en |->
    !address_latch_en && !chip_select_n && output_strobe_n && io_oe) else $error("bad cmd");
  a_addr_latch_clean: assert property ($rose(write_strobe_n) && address_latch_en |->
    !command_latch_en && !chip_select_n && output_strobe_n && io_oe) else $error("bad addr");
  a_one_latch_only: assert property (!(command_latch_en && address_latch_en))
    else $error("both latches");
  a_read_cycle_quiet: assert property (!output_strobe_n |-> write_strobe_n &&
    !command_latch_en && !address_latch_en && !chip_select_n && !io_oe) else $error("bad read");
  a_busy_read_hold: assert property ($fell(output_strobe_n) |-> $past(ready_busy_n))
    else $error("read while busy");
  a_strobe_low_width: assert property ($fell(write_strobe_n) |-> !write_strobe_n [*4])
    else $error("short strobe");
  a_data_held_steady: assert property (!write_strobe_n |-> io_oe && $stable(io_out) &&
    $stable(write_guard_n)) else $error("data moved");
  a_error_bus_idle: assert property (addr_error |-> write_strobe_n && !address_latch_en)
    else $error("bus used on error");
  a_standby_released: assert property (chip_select_n |-> !io_oe && output_strobe_n)
    else $error("driving in standby");
  c_cmd: cover property ($rose(write_strobe_n) && command_latch_en);
  c_err: cover property (addr_error);
  c_read: cover property ($fell(output_strobe_n));
endmodule

bind nand_host nand_host_props nand_host_props_i (.ref_clk(ref_clk), .reset_n(reset_n),
  .addr_error(addr_error), .chip_select_n(chip_select_n), .command_latch_en(command_latch_en),
  .address_latch_en(address_latch_en), .write_strobe_n(write_strobe_n),
  .output_strobe_n(output_strobe_n), .write_guard_n(write_guard_n),
  .ready_busy_n(ready_busy_n), .io_out(io_out), .io_oe(io_oe));

// ==== verif/nand_dev.sv ====
// Behavioural NAND device answering the host's bus cycles
module nand_dev (
  input wire chip_select_n,
  input wire command_latch_en,
  input wire address_latch_en,
  input wire write_strobe_n,
  input wire output_strobe_n,
  input wire write_guard_n,
  input wire hold_busy,
  input wire [7:0] io_bus,
  output wire ready_busy_n,
  output wire [7:0] dev_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cmd_log[$];
  logic [7:0] addr_log[$];
  logic [7:0] data_log[$];
  logic [7:0] rd_val = 8'h00;
  logic [7:0] col_cnt = 8'h00;
  int fall_cnt = 0;
  logic drv = 1'b0;
  logic cmd_guard = 1'b0;
  realtime t_fall = 0;
  assign ready_busy_n = !hold_busy;
  // Undriven bus shows the inverse so a stale byte never passes as fresh
  assign dev_out = (drv && !chip_select_n) ? rd_val : ~rd_val;
  always @(negedge write_strobe_n) t_fall = $realtime;
  always @(posedge write_strobe_n) begin
    if (!chip_select_n && output_strobe_n && $realtime - t_fall >= 5.0) begin
      if (command_latch_en && !address_latch_en) begin
        cmd_log.push_back(io_bus);
        cmd_guard = write_guard_n;
      end else if (address_latch_en && !command_latch_en) addr_log.push_back(io_bus);
      else if (!command_latch_en && !address_latch_en && write_guard_n) begin
        data_log.push_back(io_bus);
      end
    end
  end
  always @(negedge output_strobe_n) begin
    fall_cnt++;
    if (!chip_select_n && write_strobe_n && ready_busy_n) begin
      rd_val = 8'hC0 + col_cnt;
      col_cnt = col_cnt + 8'h01;
      drv = 1'b1;
    end
  end
  // Output hold after the strobe rises, then the bus floats
  always @(posedge output_strobe_n) drv <= #3 1'b0;
endmodule

// ==== verif/nand_host_tb.sv ====
// Self-checking bench for the NAND host controller
module nand_host_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic req_valid = 1'b0;
  logic [2:0] req_kind = 3'h0;
  logic [7:0] req_byte = 8'h00;
  logic [12:0] req_col = 13'h0000;
  logic [5:0] req_wl = 6'h00;
  logic [10:0] req_blk = 11'h000;
  logic req_modify = 1'b0;
  logic rd_ready = 1'b0;
  logic hold_busy = 1'b0;
  wire req_ready, rd_valid, busy, addr_error, cs_n, cle, ale, we_n, re_n, wp_n, rb_n, io_oe;
  wire [7:0] rd_byte, io_out, dev_out, io_bus;
  int err_count = 0;
  int checked = 0;
  int pulses = 0;
  assign io_bus = io_oe ? io_out : dev_out;
  always #2.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (addr_error === 1'b1) pulses++;
  nand_host #(.FIFO_DEPTH(8), .FIFO_AW(3)) nand_host_i (.ref_clk(ref_clk), .reset_n(reset_n),
    .req_valid(req_valid), .req_ready(req_ready), .req_kind(req_kind), .req_byte(req_byte),
    .req_col(req_col), .req_wl(req_wl), .req_blk(req_blk), .req_modify(req_modify),
    .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_byte(rd_byte), .busy(busy),
    .addr_error(addr_error), .chip_select_n(cs_n), .command_latch_en(cle),
    .address_latch_en(ale), .write_strobe_n(we_n), .output_strobe_n(re_n),
    .write_guard_n(wp_n), .ready_busy_n(rb_n), .io_in(io_bus), .io_out(io_out), .io_oe(io_oe));
  nand_dev nand_dev_i (.chip_select_n(cs_n), .command_latch_en(cle), .address_latch_en(ale),
    .write_strobe_n(we_n), .output_strobe_n(re_n), .write_guard_n(wp_n),
    .hold_busy(hold_busy), .io_bus(io_bus), .ready_busy_n(rb_n), .dev_out(dev_out));
  task automatic check(input logic [19:0] seen, input logic [19:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    if (err_count == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic issue(input logic [2:0] k, input logic [7:0] b, input logic m);
    int n;
    n = 0;
    req_kind <= k;
    req_byte <= b;
    req_modify <= m;
    req_valid <= 1'b1;
    @(posedge ref_clk);
    while (req_ready !== 1'b1 && n < 100) begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= 100) err_count++;
    req_valid <= 1'b0;
  endtask
  task automatic settle();
    int n;
    n = 0;
    @(posedge ref_clk);
    while (busy !== 1'b0 && n < 500) begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= 500) err_count++;
    @(posedge ref_clk);
  endtask
  task automatic t_cmd();
    issue(3'h0, 8'h80, 1'b1);
    settle();
    check(nand_dev_i.cmd_log[0], 8'h80);
    check(nand_dev_i.cmd_guard, 1'b1);
    check(cs_n, 1'b1);
    issue(3'h1, 8'h3C, 1'b0);
    settle();
    check(nand_dev_i.addr_log[0], 8'h3C);
  endtask
  task automatic t_addr(input logic [12:0] c, input logic [5:0] w, input logic [10:0] b);
    int i;
    i = nand_dev_i.addr_log.size();
    req_col <= c;
    req_wl <= w;
    req_blk <= b;
    issue(3'h4, 8'h00, 1'b1);
    settle();
    check(nand_dev_i.addr_log.size() - i, 5);
    check(nand_dev_i.addr_log[i], c[7:0]);
    check(nand_dev_i.addr_log[i+1], {3'h0, c[12:8]});
    check(nand_dev_i.addr_log[i+2], {b[1:0], w});
    check(nand_dev_i.addr_log[i+3], b[9:2]);
    check(nand_dev_i.addr_log[i+4], {7'h00, b[10]});
    check({nand_dev_i.addr_log[i+4][0], nand_dev_i.addr_log[i+3],
      nand_dev_i.addr_log[i+2]}, {b, w});
  endtask
  task automatic t_bad();
    int i;
    int p;
    i = nand_dev_i.addr_log.size();
    p = pulses;
    req_col <= 13'h1080;
    issue(3'h4, 8'h00, 1'b1);
    settle();
    repeat (3) @(posedge ref_clk);
    check(pulses - p, 1);
    check(nand_dev_i.addr_log.size() - i, 0);
    // An undefined request kind must leave the bus untouched
    i = nand_dev_i.cmd_log.size();
    issue(3'h7, 8'hFF, 1'b0);
    settle();
    check(nand_dev_i.cmd_log.size() - i, 0);
    check(cs_n, 1'b1);
  endtask
  task automatic t_din();
    issue(3'h2, 8'h5A, 1'b1);
    settle();
    issue(3'h2, 8'hA5, 1'b0);
    settle();
    check(nand_dev_i.data_log.size(), 1);
    check(nand_dev_i.data_log[0], 8'h5A);
  endtask
  task automatic t_read();
    int n;
    int k;
    hold_busy <= 1'b1;
    issue(3'h3, 8'h00, 1'b0);
    repeat (30) @(posedge ref_clk);
    check(nand_dev_i.fall_cnt, 0);
    hold_busy <= 1'b0;
    settle();
    for (n = 1; n < 8; n++) begin
      issue(3'h3, 8'h00, 1'b0);
      settle();
    end
    // Ninth read must wait on the full buffer
    issue(3'h3, 8'h00, 1'b0);
    repeat (40) @(posedge ref_clk);
    check(nand_dev_i.fall_cnt, 8);
    rd_ready <= 1'b1;
    n = 0;
    k = 0;
    while (k < 9 && n < 400) begin
      @(posedge ref_clk);
      n++;
      if (rd_valid === 1'b1) begin
        check(rd_byte, 8'hC0 + k);
        k++;
      end
    end
    check(k, 9);
  endtask
  initial begin
    repeat (4) @(posedge ref_clk);
    reset_n <= 1'b1;
    t_cmd();
    t_addr(13'h0ABC, 6'h2D, 11'h5E3);
    t_addr(13'h107F, 6'h3F, 11'h7FF);
    t_bad();
    t_din();
    t_read();
    end_of_test();
  end
  // Whole sequence needs a few hundred cycles; the limit of 20000 cycles allows about forty times that
  initial begin
    #100000;
    err_count++;
    end_of_test();
  end
endmodule
